// ### design/emcr_mac_regs.sv
// control and status registers of the ethernet mac, direct and indirect
// assumes bar1 hit, strobes and frame events come from logic on i_clk_sys
module emcr_mac_regs (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_bar1_hit,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [emcr_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [emcr_pkg::DATA_W-1:0] i_reg_wdata,
  output logic      [emcr_pkg::DATA_W-1:0] o_reg_rdata,
  output logic                             o_reg_ack,
  input  wire logic                        i_rx_crc_fail,
  input  wire logic [emcr_pkg::LEN_W-1:0]  i_rx_frame_bytes,
  input  wire logic                        i_rx_len_mismatch,
  input  wire logic                        i_rx_dest_match,
  input  wire logic                        i_rx_oversize,
  input  wire logic                        i_tx_underrun,
  input  wire logic                        i_tx_oversize,
  output logic                             o_core_soft_reset,
  output logic                             o_counter_block_reset,
  output logic                             o_rx_reset,
  output logic                             o_tx_reset,
  output logic                             o_rx_enable,
  output logic                             o_rx_fcs_pass,
  output logic                             o_rx_length_check,
  output logic                             o_rx_frame_accept,
  output logic                             o_tx_enable,
  output logic                             o_tx_fcs_insert,
  output logic                             o_tx_send_allowed,
  output logic                             o_mdio_enable,
  output logic                             o_mdc,
  output logic                             o_mdc_active
);
  import emcr_pkg::*;

  // ************************************************************
  // register access decode
  // ************************************************************
  logic              wr_hit;
  logic              rd_hit;
  logic              wr_reset_word;
  logic              wr_core;
  logic              wr_stats;
  logic              wr_ind_ctrl;
  logic              ind_write;
  logic              ind_read;
  logic [IND_W-1:0]  ind_addr;
  logic [31:0]       ind_data_reg;
  logic [31:0]       rx_cfg_reg;
  logic [31:0]       tx_cfg_reg;
  logic [31:0]       mgmt_cfg_reg;
  logic [31:0]       filt_cfg_reg;
  logic [3:0]        core_cnt_reg;
  logic              rx_rst_reg;
  logic              tx_rst_reg;
  logic              stats_rst_reg;
  logic              mgmt_ok_reg;
  logic              rx_accept_reg;
  logic              tx_allow_reg;
  logic [31:0]       rdata_reg;
  logic              ack_reg;
  logic [31:0]       crc_count;
  logic [31:0]       len_count;
  logic [31:0]       und_count;
  logic              crc_event;
  logic              len_event;
  logic              und_event;
  logic              mdc_run;
  logic              core_busy;

  assign wr_hit        = i_reg_wr && i_bar1_hit;
  assign rd_hit        = i_reg_rd && i_bar1_hit;
  assign wr_reset_word = wr_hit && (i_reg_addr == OFF_RESET);
  assign wr_core       = wr_reset_word && i_reg_wdata[CORE_RST_BIT];
  assign wr_stats      = wr_reset_word && i_reg_wdata[STATS_RST_BIT];
  assign wr_ind_ctrl   = wr_hit && (i_reg_addr == OFF_IND_CTRL);
  assign ind_addr      = i_reg_wdata[IND_W-1:0];
  // indirect words are reached only through the control and data words
  assign ind_write     = wr_ind_ctrl && i_reg_wdata[IND_WR_BIT];
  assign ind_read      = wr_ind_ctrl && !i_reg_wdata[IND_WR_BIT];
  assign core_busy     = (core_cnt_reg != 4'h0);

  // ************************************************************
  // core and statistics reset
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      core_cnt_reg <= 4'h0;
    end else if (wr_core) begin
      core_cnt_reg <= 4'(CORE_RST_CYCLES);
    end else if (core_busy) begin
      core_cnt_reg <= core_cnt_reg - 4'h1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      stats_rst_reg <= 1'b0;
    end else begin
      stats_rst_reg <= wr_stats;
    end
  end

  // ************************************************************
  // indirect data word
  // ************************************************************
  function automatic logic [31:0] ind_mux(input logic [IND_W-1:0] a,
                                          input logic [31:0] rx,
                                          input logic [31:0] tx,
                                          input logic [31:0] mg,
                                          input logic [31:0] fl);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      IND_RX:   v = rx;
      IND_TX:   v = tx;
      IND_MGMT: v = mg;
      IND_FILT: v = fl;
      default:  v = 32'h0000_0000;
    endcase
    return v;
  endfunction : ind_mux

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ind_data_reg <= 32'h0000_0000;
    end else if (wr_hit && (i_reg_addr == OFF_IND_DATA)) begin
      ind_data_reg <= i_reg_wdata;
    end else if (ind_read) begin
      ind_data_reg <= ind_mux(ind_addr, rx_cfg_reg, tx_cfg_reg,
                              mgmt_cfg_reg, filt_cfg_reg);
    end
  end

  // ************************************************************
  // receive configuration
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || core_busy) begin
      rx_cfg_reg <= RX_CFG_RST;
      rx_rst_reg <= 1'b0;
    end else if (ind_write && (ind_addr == IND_RX)) begin
      if (ind_data_reg[CFG_RST_BIT]) begin
        rx_cfg_reg <= RX_CFG_RST;
        rx_rst_reg <= 1'b1;
      end else begin
        rx_cfg_reg <= ind_data_reg & RX_CFG_MASK;
        rx_rst_reg <= 1'b0;
      end
    end else begin
      rx_rst_reg <= 1'b0;
    end
  end

  // ************************************************************
  // transmit configuration
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || core_busy) begin
      tx_cfg_reg <= TX_CFG_RST;
      tx_rst_reg <= 1'b0;
    end else if (ind_write && (ind_addr == IND_TX)) begin
      if (ind_data_reg[CFG_RST_BIT]) begin
        tx_cfg_reg <= TX_CFG_RST;
        tx_rst_reg <= 1'b1;
      end else begin
        tx_cfg_reg <= ind_data_reg & TX_CFG_MASK;
        tx_rst_reg <= 1'b0;
      end
    end else begin
      tx_rst_reg <= 1'b0;
    end
  end

  // ************************************************************
  // management and address filter
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || core_busy) begin
      mgmt_cfg_reg <= MGMT_RST;
      mgmt_ok_reg  <= 1'b0;
    end else if (ind_write && (ind_addr == IND_MGMT)) begin
      mgmt_cfg_reg <= ind_data_reg & MGMT_MASK;
      mgmt_ok_reg  <= (ind_data_reg[DIV_W-1:0] >= DIV_W'(MDC_MIN_DIV));
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || core_busy) begin
      filt_cfg_reg <= FILT_RST;
    end else if (ind_write && (ind_addr == IND_FILT)) begin
      filt_cfg_reg <= ind_data_reg & FILT_MASK;
    end
  end
  assign mdc_run = mgmt_ok_reg && mgmt_cfg_reg[MDIO_EN_BIT];
  emcr_mdc_gen u_mdc (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_run     (mdc_run),
    .i_divide  (mgmt_cfg_reg[DIV_W-1:0]),
    .o_mdc     (o_mdc)
  );

  // ************************************************************
  // frame admission
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_accept_reg <= 1'b0;
    end else begin
      rx_accept_reg <= rx_cfg_reg[PATH_EN_BIT]
        && (filt_cfg_reg[ACCEPT_BIT] || i_rx_dest_match)
        && (rx_cfg_reg[OVERSIZE_BIT] || !i_rx_oversize);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_allow_reg <= 1'b0;
    end else begin
      tx_allow_reg <= tx_cfg_reg[PATH_EN_BIT]
        && (tx_cfg_reg[OVERSIZE_BIT] || !i_tx_oversize);
    end
  end

  // ************************************************************
  // statistics counters
  // ************************************************************
  assign crc_event = rx_cfg_reg[PATH_EN_BIT] && i_rx_crc_fail
    && (i_rx_frame_bytes >= LEN_W'(MIN_FRAME_BYTES));
  assign len_event = rx_cfg_reg[PATH_EN_BIT] && i_rx_len_mismatch
    && !rx_cfg_reg[LEN_DIS_BIT];
  assign und_event = tx_cfg_reg[PATH_EN_BIT] && i_tx_underrun;
  emcr_event_counter #(.WIDTH(DATA_W)) u_crc_cnt (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_clear   (wr_stats),
    .i_event   (crc_event),
    .o_count   (crc_count)
  );
  emcr_event_counter #(.WIDTH(DATA_W)) u_len_cnt (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_clear   (wr_stats),
    .i_event   (len_event),
    .o_count   (len_count)
  );
  emcr_event_counter #(.WIDTH(DATA_W)) u_und_cnt (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_clear   (wr_stats),
    .i_event   (und_event),
    .o_count   (und_count)
  );

  // ************************************************************
  // read data and acknowledge
  // ************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rdata_reg <= 32'h0000_0000;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= wr_hit || rd_hit;
      if (rd_hit) begin
        case (i_reg_addr)
          OFF_RESET:    rdata_reg <= {core_busy, 31'h0000_0000};
          OFF_IND_DATA: rdata_reg <= ind_data_reg;
          OFF_CRC_CNT:  rdata_reg <= crc_count;
          OFF_LEN_CNT:  rdata_reg <= len_count;
          OFF_UND_CNT:  rdata_reg <= und_count;
          default:      rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_reg_rdata           = rdata_reg;
  assign o_reg_ack             = ack_reg;
  assign o_core_soft_reset     = core_busy;
  assign o_counter_block_reset = stats_rst_reg;
  assign o_rx_reset            = rx_rst_reg;
  assign o_tx_reset            = tx_rst_reg;
  assign o_rx_enable           = rx_cfg_reg[PATH_EN_BIT];
  assign o_rx_fcs_pass         = rx_cfg_reg[FCS_BIT];
  assign o_rx_length_check     = !rx_cfg_reg[LEN_DIS_BIT];
  assign o_rx_frame_accept     = rx_accept_reg;
  assign o_tx_enable           = tx_cfg_reg[PATH_EN_BIT];
  assign o_tx_fcs_insert       = !tx_cfg_reg[FCS_BIT];
  assign o_tx_send_allowed     = tx_allow_reg;
  assign o_mdio_enable         = mgmt_cfg_reg[MDIO_EN_BIT];
  assign o_mdc_active          = mdc_run;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  core_rst_hold_a: assert property (wr_core |=> o_core_soft_reset[*8])
    else $error("core reset not held for its length");
  core_rst_end_a: assert property ((wr_core ##1 !wr_core[*8])
    |-> ##1 !o_core_soft_reset)
    else $error("core reset bit did not clear");
  stats_clear_a: assert property (wr_stats |=> crc_count <= 32'h1
    && len_count <= 32'h1 && und_count <= 32'h1)
    else $error("statistics not cleared");
  crc_count_a: assert property (crc_event && !wr_stats
    |=> crc_count == $past(crc_count) + 32'h1)
    else $error("crc failure not counted");
  crc_short_a: assert property (!crc_event && !wr_stats
    |=> $stable(crc_count))
    else $error("crc count moved without a counted frame");
  len_skip_a: assert property (rx_cfg_reg[LEN_DIS_BIT] && !wr_stats
    |=> $stable(len_count))
    else $error("length mismatch counted with check off");
  underrun_a: assert property (und_event && !wr_stats
    |=> und_count == $past(und_count) + 32'h1)
    else $error("underrun not counted");
  rx_rst_a: assert property (ind_write && ind_addr == IND_RX
    && ind_data_reg[CFG_RST_BIT] && !core_busy
    |=> o_rx_reset && rx_cfg_reg == RX_CFG_RST ##1 !o_rx_reset)
    else $error("receiver reset wrong");
  tx_rst_a: assert property (ind_write && ind_addr == IND_TX
    && ind_data_reg[CFG_RST_BIT] && !core_busy
    |=> o_tx_reset && tx_cfg_reg == TX_CFG_RST)
    else $error("transmitter reset wrong");
  rx_off_a: assert property (!rx_cfg_reg[PATH_EN_BIT]
    |=> !o_rx_frame_accept)
    else $error("frame accepted with receiver off");
  accept_all_a: assert property (filt_cfg_reg[ACCEPT_BIT]
    && rx_cfg_reg[PATH_EN_BIT] && !i_rx_oversize |=> o_rx_frame_accept)
    else $error("promiscuous frame refused");
  oversize_a: assert property (!rx_cfg_reg[OVERSIZE_BIT] && i_rx_oversize
    |=> !o_rx_frame_accept)
    else $error("oversize frame accepted");

  core_rst_c: cover property (wr_core ##9 !o_core_soft_reset);
  crc_cnt_c: cover property (crc_event ##1 crc_count != 32'h0);
  mdc_run_c: cover property (mdc_run ##[1:100] $rose(o_mdc));
endmodule : emcr_mac_regs

// ### include/emcr_pkg.sv
// constants, offsets, field positions and reset values of the mac config block
// assumes one 200 MHz system clock and a bar1 register window decoded upstream
package emcr_pkg;
  localparam int unsigned SYS_CLK_HZ      = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned MDC_MAX_HZ      = 2_500_000;
  localparam int unsigned MDC_MIN_DIV     = (SYS_CLK_HZ + 2 * MDC_MAX_HZ - 1)
                                            / (2 * MDC_MAX_HZ) - 1;
  localparam int unsigned CORE_RST_NS     = 40;
  localparam int unsigned CORE_RST_CYCLES = (CORE_RST_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned MIN_FRAME_BYTES = 64;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned IND_W           = 10;
  localparam int unsigned DIV_W           = 6;
  localparam int unsigned LEN_W           = 16;
  // direct offsets inside bar1
  localparam logic [15:0] OFF_RESET    = 16'h0000;
  localparam logic [15:0] OFF_IND_CTRL = 16'h0024;
  localparam logic [15:0] OFF_IND_DATA = 16'h0028;
  localparam logic [15:0] OFF_CRC_CNT  = 16'h0298;
  localparam logic [15:0] OFF_LEN_CNT  = 16'h02b8;
  localparam logic [15:0] OFF_UND_CNT  = 16'h02f0;
  // indirect word addresses
  localparam logic [9:0]  IND_RX       = 10'h240;
  localparam logic [9:0]  IND_TX       = 10'h280;
  localparam logic [9:0]  IND_MGMT     = 10'h340;
  localparam logic [9:0]  IND_FILT     = 10'h390;
  // field positions
  localparam int unsigned CORE_RST_BIT  = 31;
  localparam int unsigned STATS_RST_BIT = 18;
  localparam int unsigned CFG_RST_BIT   = 31;
  localparam int unsigned OVERSIZE_BIT  = 30;
  localparam int unsigned FCS_BIT       = 29;
  localparam int unsigned PATH_EN_BIT   = 28;
  localparam int unsigned LEN_DIS_BIT   = 25;
  localparam int unsigned MDIO_EN_BIT   = 6;
  localparam int unsigned ACCEPT_BIT    = 31;
  localparam int unsigned IND_WR_BIT    = 15;
  // reset values and writable masks
  localparam logic [31:0] RX_CFG_RST  = 32'h7000_0000;
  localparam logic [31:0] TX_CFG_RST  = 32'h5000_0000;
  localparam logic [31:0] MGMT_RST    = 32'h0000_0000;
  localparam logic [31:0] FILT_RST    = 32'h0000_0000;
  localparam logic [31:0] RX_CFG_MASK = 32'h7200_0000;
  localparam logic [31:0] TX_CFG_MASK = 32'h7000_0000;
  localparam logic [31:0] MGMT_MASK   = 32'h0000_007f;
  localparam logic [31:0] FILT_MASK   = 32'h8000_0000;
endpackage : emcr_pkg

// ### design/emcr_event_counter.sv
// one statistics counter, wrapping, cleared by a pulse
// assumes event and clear come from logic on the same clock
module emcr_event_counter #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clear,
  input  wire logic             i_event,
  output logic [WIDTH-1:0]      o_count
);
  logic [WIDTH-1:0] count_reg;

  // an event in the clearing cycle is kept as a count of one
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      count_reg <= '0;
    end else if (i_event) begin
      count_reg <= i_clear ? WIDTH'(1) : count_reg + WIDTH'(1);
    end else if (i_clear) begin
      count_reg <= '0;
    end
  end

  assign o_count = count_reg;
endmodule : emcr_event_counter

// ### design/emcr_mdc_gen.sv
// management clock divider, output low while stopped
// assumes divide and run are flops on the same clock
module emcr_mdc_gen (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_run,
  input  wire logic [emcr_pkg::DIV_W-1:0] i_divide,
  output logic                           o_mdc
);
  import emcr_pkg::*;

  logic [DIV_W-1:0] div_cnt_reg;
  logic             mdc_reg;

  // half period is divide plus one system cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_run) begin
      div_cnt_reg <= '0;
      mdc_reg     <= 1'b0;
    end else if (div_cnt_reg >= i_divide) begin
      div_cnt_reg <= '0;
      mdc_reg     <= !mdc_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
    end
  end

  assign o_mdc = mdc_reg;

  mdc_stop_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !i_run |=> !o_mdc)
    else $error("management clock moved while stopped");
endmodule : emcr_mdc_gen

// ### tb/emcr_phy_model.sv
// frame event source standing in for the receive and transmit datapath
// assumes the bench calls frame from one process, off the rising edge
module emcr_phy_model (
  input  wire logic        i_clk_sys,
  output logic             o_crc_fail,
  output logic [15:0]      o_frame_bytes,
  output logic             o_len_mismatch,
  output logic             o_underrun
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_crc_fail = 1'b0;
    o_len_mismatch = 1'b0;
    o_underrun = 1'b0;
    o_frame_bytes = 16'h0000;
  end
  // **************
  // one frame event: 0 crc fail, 1 length mismatch, 2 underrun
  // **************
  task automatic frame(input int kind, input logic [15:0] bytes);
    @(negedge i_clk_sys);
    o_frame_bytes = bytes;
    o_crc_fail = (kind == 0);
    o_len_mismatch = (kind == 1);
    o_underrun = (kind == 2);
    @(negedge i_clk_sys);
    o_crc_fail = 1'b0;
    o_len_mismatch = 1'b0;
    o_underrun = 1'b0;
    o_frame_bytes = ~bytes;
  endtask : frame
endmodule : emcr_phy_model

// ### tb/testbench.sv
// self-checking bench of the mac control and status registers
// assumes emcr_pkg and the design files are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import emcr_pkg::*;
  logic        clk, rst, hit, wr, rd, dm, rxo, txo, crc, lm, und;
  logic        csr, cbr, rxr, txr, rxe, fcp, lck, acc, txe, fci, txa, mde, mdc, mda, ack;
  logic [15:0] addr, fb;
  logic [31:0] wd, rdat, q;
  int          err_total, compares, cyc, n, n_cbr, n_rxr, n_txr;
  emcr_phy_model i_phy (.i_clk_sys(clk), .o_crc_fail(crc), .o_frame_bytes(fb),
    .o_len_mismatch(lm), .o_underrun(und));
  emcr_mac_regs i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_bar1_hit(hit), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_ack(ack),
    .i_rx_crc_fail(crc), .i_rx_frame_bytes(fb), .i_rx_len_mismatch(lm),
    .i_rx_dest_match(dm), .i_rx_oversize(rxo), .i_tx_underrun(und), .i_tx_oversize(txo),
    .o_core_soft_reset(csr), .o_counter_block_reset(cbr), .o_rx_reset(rxr),
    .o_tx_reset(txr), .o_rx_enable(rxe), .o_rx_fcs_pass(fcp), .o_rx_length_check(lck),
    .o_rx_frame_accept(acc), .o_tx_enable(txe), .o_tx_fcs_insert(fci),
    .o_tx_send_allowed(txa), .o_mdio_enable(mde), .o_mdc(mdc), .o_mdc_active(mda));
  // **************
  // shared tasks
  // **************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    chk({31'h0, ack}, {31'h0, hit});
    q = rdat;
  endtask : bus
  task automatic iwr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, OFF_IND_DATA, d);
    bus(1'b1, OFF_IND_CTRL, {16'h0000, 1'b1, 5'h00, a});
    repeat (2) @(negedge clk);
  endtask : iwr
  task automatic ird(input logic [9:0] a, input logic [31:0] e);
    bus(1'b1, OFF_IND_CTRL, {22'h000000, a});
    bus(1'b0, OFF_IND_DATA, 32'h0000_0000);
    chk(q, e);
  endtask : ird
  task automatic give_verdict;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // **************
  // scenarios
  // **************
  task automatic t_defaults;
    ird(IND_RX, RX_CFG_RST);
    ird(IND_TX, TX_CFG_RST);
    ird(IND_MGMT, MGMT_RST);
    ird(IND_FILT, FILT_RST);
    chk({26'h0, rxe, fcp, lck, txe, fci, mde}, 32'h3e);
  endtask : t_defaults
  task automatic t_counters;
    i_phy.frame(0, 16'h0040);
    i_phy.frame(0, 16'h003f);
    i_phy.frame(1, 16'h0100);
    i_phy.frame(2, 16'h0100);
    i_phy.frame(2, 16'h0100);
    bus(1'b0, OFF_CRC_CNT, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, OFF_LEN_CNT, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, OFF_UND_CNT, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, OFF_RESET, 32'h0004_0000);
    bus(1'b0, OFF_RESET, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, OFF_UND_CNT, 32'h0);
    chk(q, 32'h0);
    chk(n_cbr, 32'd1);
  endtask : t_counters
  task automatic t_core;
    iwr(IND_FILT, 32'h8000_0000);
    bus(1'b1, OFF_RESET, 32'h8000_0000);
    chk({31'h0, csr}, 32'h1);
    bus(1'b0, OFF_RESET, 32'h0);
    chk(q, 32'h8000_0000);
    repeat (10) @(negedge clk);
    bus(1'b0, OFF_RESET, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, csr}, 32'h0);
    ird(IND_FILT, FILT_RST);
  endtask : t_core
  task automatic t_rx;
    dm = 1'b1;
    rxo = 1'b1;
    iwr(IND_RX, 32'h1200_0000);
    chk({29'h0, acc, fcp, lck}, 32'h0);
    i_phy.frame(1, 16'h0100);
    bus(1'b0, OFF_LEN_CNT, 32'h0);
    chk(q, 32'h0);
    rxo = 1'b0;
    dm = 1'b0;
    repeat (2) @(negedge clk);
    chk({31'h0, acc}, 32'h0);
    iwr(IND_FILT, 32'h8000_0000);
    chk({31'h0, acc}, 32'h1);
    iwr(IND_RX, 32'h0000_0000);
    i_phy.frame(0, 16'h0100);
    bus(1'b0, OFF_CRC_CNT, 32'h0);
    chk(q, 32'h0);
    iwr(IND_RX, 32'h8000_0000);
    ird(IND_RX, RX_CFG_RST);
    chk(n_rxr, 32'd1);
    rxo = 1'b1;
    repeat (2) @(negedge clk);
    chk({31'h0, acc}, 32'h1);
    rxo = 1'b0;
  endtask : t_rx
  task automatic t_tx;
    txo = 1'b1;
    iwr(IND_TX, 32'h3000_0000);
    chk({30'h0, fci, txa}, 32'h0);
    iwr(IND_TX, 32'h0000_0000);
    chk({31'h0, txe}, 32'h0);
    i_phy.frame(2, 16'h0100);
    bus(1'b0, OFF_UND_CNT, 32'h0);
    chk(q, 32'h0);
    iwr(IND_TX, 32'h8000_0000);
    ird(IND_TX, TX_CFG_RST);
    chk(n_txr, 32'd1);
    chk({31'h0, txa}, 32'h1);
  endtask : t_tx
  task automatic t_mgmt;
    iwr(IND_MGMT, 32'h0000_0067);
    chk({30'h0, mde, mda}, 32'h3);
    n = 0;
    while (mdc !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (mdc === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n, 32'd40);
    iwr(IND_MGMT, 32'h0000_004a);
    repeat (100) @(negedge clk);
    chk({30'h0, mda, mdc}, 32'h0);
  endtask : t_mgmt
  task automatic t_bus;
    bus(1'b0, 16'h0100, 32'h0);
    chk(q, 32'h0);
    hit = 1'b0;
    bus(1'b1, OFF_RESET, 32'h8000_0000);
    chk({31'h0, csr}, 32'h0);
    hit = 1'b1;
  endtask : t_bus
  // **************
  // clock, timeout, main sequence
  // **************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // count the one-cycle reset pulses where they stand
  always @(negedge clk) begin
    n_cbr += cbr;
    n_rxr += rxr;
    n_txr += txr;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    {rst, hit, wr, rd, dm, rxo, txo} = 7'b1100000;
    addr = 16'h0000;
    wd = 32'h0000_0000;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_defaults();
    t_counters();
    t_core();
    t_rx();
    t_tx();
    t_mgmt();
    t_bus();
    give_verdict();
  end
endmodule : testbench
